//--- src/fecs_regs.svh
// Command codes, unlock addresses and timing counts for the erase sequencer.
// Assumes a 125 MHz controller clock and a word-mode flash bus.
`ifndef FECS_REGS_SVH
`define FECS_REGS_SVH

`define FECS_ADDR_UNLOCK1   20'h00555
`define FECS_ADDR_UNLOCK2   20'h002AA
`define FECS_DATA_UNLOCK1   8'hAA
`define FECS_DATA_UNLOCK2   8'h55
`define FECS_DATA_SETUP     8'h80
`define FECS_DATA_CHIP      8'h10
`define FECS_DATA_SECTOR    8'h30
`define FECS_DATA_SUSPEND   8'hB0
`define FECS_DATA_RESUME    8'h30
// Sector select field in the address
`define FECS_SECT_LSB       12
`define FECS_SECT_MSB       19
// Status bit positions
`define FECS_BIT_POLL       7
`define FECS_BIT_TOGGLE     6
`define FECS_BIT_TIMER      3
`define FECS_BIT_STOGGLE    2
// Timing
`define FECS_CLK_MHZ        125
`define FECS_WINDOW_US      50
`define FECS_WINDOW_CYC     (`FECS_WINDOW_US * `FECS_CLK_MHZ)
`define FECS_SUSPEND_US     20
`define FECS_SUSPEND_CYC    (`FECS_SUSPEND_US * `FECS_CLK_MHZ)
`define FECS_WE_LOW_CYC     4
`define FECS_WE_HIGH_CYC    4
`define FECS_RD_CYC         10

`endif

//--- src/fecs_pkg.sv
// Types shared by the erase sequencer files.
// Assumes nothing beyond the constants header.
package fecs_pkg;
    typedef enum logic [2:0] {
        FECS_OP_CHIP    = 3'h0,
        FECS_OP_SECTOR  = 3'h1,
        FECS_OP_ADD     = 3'h2,
        FECS_OP_SUSPEND = 3'h3,
        FECS_OP_RESUME  = 3'h4,
        FECS_OP_READ    = 3'h5
    } fecs_op_t;

    typedef enum logic [5:0] {
        FECS_IDLE  = 6'h01,
        FECS_LOAD  = 6'h02,
        FECS_WR    = 6'h04,
        FECS_RD    = 6'h08,
        FECS_NEXT  = 6'h10,
        FECS_DONE  = 6'h20
    } fecs_state_t;
endpackage

//--- src/fecs_cycle.sv
// One flash bus cycle: write strobe or read strobe with data capture.
// Assumes the flash meets its timing within the programmed strobe counts.
`timescale 1ns/10ps
`include "fecs_regs.svh"
module fecs_cycle #(
    parameter int AW = 20,
    parameter int DW = 16
) (
    input  wire logic          clk,
    input  wire logic          resetn,
    input  wire logic          start,
    input  wire logic          is_read,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic               done,
    output logic [DW-1:0]      rdata,
    output logic [AW-1:0]      f_addr_ff,
    output logic [DW-1:0]      f_dq_o_ff,
    output logic               f_dq_oe_ff,
    output logic               f_we_n_ff,
    output logic               f_oe_n_ff,
    output logic               f_ce_n_ff,
    input  wire logic [DW-1:0] f_dq_i
);
    logic [4:0] cnt_ff;
    logic       busy_ff;
    logic       rd_ff;
    logic       done_ff;
    logic [DW-1:0] rdata_ff;
    logic [4:0] low_cnt;
    logic       last;

    ////////////////////////////////////////////////////////////////////////
    // Strobe timing: low phase then recovery high phase
    assign low_cnt = rd_ff ? 5'(`FECS_RD_CYC) : 5'(`FECS_WE_LOW_CYC);
    assign last    = busy_ff && (cnt_ff == low_cnt + 5'(`FECS_WE_HIGH_CYC));
    assign done    = done_ff;
    assign rdata   = rdata_ff;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_ff     <= 5'h00;
            busy_ff    <= 1'b0;
            rd_ff      <= 1'b0;
            done_ff    <= 1'b0;
            rdata_ff   <= '0;
            f_addr_ff  <= '0;
            f_dq_o_ff  <= '0;
            f_dq_oe_ff <= 1'b0;
            f_we_n_ff  <= 1'b1;
            f_oe_n_ff  <= 1'b1;
            f_ce_n_ff  <= 1'b1;
        end else begin
            done_ff <= last;
            if (start && !busy_ff) begin
                busy_ff    <= 1'b1;
                rd_ff      <= is_read;
                cnt_ff     <= 5'h00;
                f_addr_ff  <= addr;
                f_dq_o_ff  <= wdata;
                f_dq_oe_ff <= !is_read;
                f_ce_n_ff  <= 1'b0;
                f_we_n_ff  <= is_read;
                f_oe_n_ff  <= !is_read;
            end else if (busy_ff) begin
                cnt_ff <= cnt_ff + 5'h01;
                // Rising WE edge ends the command cycle
                if (cnt_ff == low_cnt) begin
                    f_we_n_ff <= 1'b1;
                    f_oe_n_ff <= 1'b1;
                    if (rd_ff)
                        rdata_ff <= f_dq_i;
                end
                if (last) begin
                    busy_ff    <= 1'b0;
                    f_ce_n_ff  <= 1'b1;
                    f_dq_oe_ff <= 1'b0;
                end
            end
        end
    end
endmodule

//--- src/fecs_host.sv
// Host-side erase command sequencer driving an asynchronous NOR flash.
// Assumes one flash on the pins, word mode, and a user that waits for
// ack before issuing the next order.
`timescale 1ns/10ps
`include "fecs_regs.svh"

// Functional notes
// - Chip erase is six writes: two unlocks, setup, two unlocks, chip code.
// - Reset aborts erase; host reissues sequence after return to read.
// - Sector erase is five writes then sector address with sector code.
// - Extra sectors any order, each gap kept under 50 us; the code allows gaps up to WINDOW_CYC + 12 cycles.
// - Host holds off interrupts while loading sector commands.
// - Resume with bank address; repeats ignored; later suspend allowed.
// - Command encoding: 555/AA, 2AA/55, 555/80, 555/10, SA/30.
module fecs_host #(
    parameter int AW         = 20,
    parameter int DW         = 16,
    parameter int WINDOW_CYC = `FECS_WINDOW_CYC,
    parameter int SUSP_CYC   = `FECS_SUSPEND_CYC
) (
    input  wire logic          clk,
    input  wire logic          resetn,
    input  wire logic          cmd_valid,
    input  wire logic [2:0]    cmd_op,
    input  wire logic [AW-1:0] cmd_addr,
    output logic               cmd_ack_ff,
    output logic [DW-1:0]      rd_data_ff,
    output logic               window_open_ff,
    output logic               intr_hold_ff,
    output logic               suspended_ff,
    output logic               chip_busy_ff,
    output logic               flash_reset_n_ff,
    input  wire logic          abort,
    output logic [AW-1:0]      f_addr,
    output logic [DW-1:0]      f_dq_o,
    output logic               f_dq_oe,
    input  wire logic [DW-1:0] f_dq_i,
    output logic               f_we_n,
    output logic               f_oe_n,
    output logic               f_ce_n,
    input  wire logic          ready_busy_n_output
);
    // Elaboration check: sector field and timers need room
    if (AW < `FECS_SECT_MSB + 1 || DW < 8 || WINDOW_CYC < 2 ||
        SUSP_CYC < 1) begin : g_bad_params
        $error("fecs_host: unsupported parameters");
    end

    fecs_pkg::fecs_state_t st_ff;
    fecs_pkg::fecs_state_t nxt_st;
    fecs_pkg::fecs_op_t    op_ff;
    logic [2:0]            idx_ff;
    logic [2:0]            nxt_idx;
    logic [AW-1:0]         a_ff;
    logic [31:0]           win_ff;
    logic [31:0]           susp_ff;
    logic                  cyc_start;
    logic                  cyc_done;
    logic [DW-1:0]         cyc_rdata;
    logic [AW-1:0]         seq_addr;
    logic [7:0]            seq_data;
    logic [2:0]            last_idx;
    logic                  single;
    logic                  is_read;
    logic                  op_ok;
    logic                  in_window;

    ////////////////////////////////////////////////////////////////////////
    // Sequence table: address and code for each write of the order
    // command encoding
    assign single = (op_ff == fecs_pkg::FECS_OP_ADD) ||
                    (op_ff == fecs_pkg::FECS_OP_SUSPEND) ||
                    (op_ff == fecs_pkg::FECS_OP_RESUME) ||
                    (op_ff == fecs_pkg::FECS_OP_READ);
    assign last_idx = single ? 3'h0 : 3'h5;
    assign is_read  = (op_ff == fecs_pkg::FECS_OP_READ);
    always_comb begin
        seq_addr = `FECS_ADDR_UNLOCK1;
        seq_data = `FECS_DATA_UNLOCK1;
        unique case (idx_ff)
            3'h1, 3'h4: begin
                seq_addr = `FECS_ADDR_UNLOCK2;
                seq_data = `FECS_DATA_UNLOCK2;
            end
            3'h2: seq_data = `FECS_DATA_SETUP;
            3'h5: begin
                // sector or bank address on the last write
                if (op_ff != fecs_pkg::FECS_OP_CHIP)
                    seq_addr = a_ff;
                if (op_ff == fecs_pkg::FECS_OP_CHIP)
                    seq_data = `FECS_DATA_CHIP;
                else if (op_ff == fecs_pkg::FECS_OP_SUSPEND)
                    seq_data = `FECS_DATA_SUSPEND;
                else if (op_ff == fecs_pkg::FECS_OP_RESUME)
                    seq_data = `FECS_DATA_RESUME;
                else
                    seq_data = `FECS_DATA_SECTOR;
            end
            default: ;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Order legality against the tracked flash state
    assign in_window = window_open_ff;
    always_comb begin
        unique case (fecs_pkg::fecs_op_t'(cmd_op))
            // no new erase while busy or suspended
            fecs_pkg::FECS_OP_CHIP,
            fecs_pkg::FECS_OP_SECTOR:
                op_ok = !chip_busy_ff && !suspended_ff &&
                        ready_busy_n_output && !in_window;
            fecs_pkg::FECS_OP_ADD:     op_ok = in_window;
            fecs_pkg::FECS_OP_SUSPEND:
                op_ok = !chip_busy_ff && !suspended_ff &&
                        (in_window || !ready_busy_n_output);
            fecs_pkg::FECS_OP_RESUME:  op_ok = suspended_ff;
            fecs_pkg::FECS_OP_READ:    op_ok = !in_window;
            default:                   op_ok = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Main state machine
    assign cyc_start = (st_ff == fecs_pkg::FECS_WR) ||
                       (st_ff == fecs_pkg::FECS_RD);
    always_comb begin
        nxt_st  = st_ff;
        nxt_idx = idx_ff;
        unique case (st_ff)
            fecs_pkg::FECS_IDLE:
                if (cmd_valid && op_ok) begin
                    nxt_st = fecs_pkg::FECS_LOAD;
                end else if (cmd_valid) begin
                    nxt_st = fecs_pkg::FECS_DONE;
                end
            fecs_pkg::FECS_LOAD: begin
                nxt_idx = single ? 3'h5 : 3'h0;
                nxt_st  = is_read ? fecs_pkg::FECS_RD : fecs_pkg::FECS_WR;
            end
            fecs_pkg::FECS_WR,
            fecs_pkg::FECS_RD:
                nxt_st = fecs_pkg::FECS_NEXT;
            fecs_pkg::FECS_NEXT:
                if (cyc_done) begin
                    if (idx_ff == 3'h5 || idx_ff == last_idx) begin
                        nxt_st = fecs_pkg::FECS_DONE;
                    end else begin
                        nxt_idx = idx_ff + 3'h1;
                        nxt_st  = fecs_pkg::FECS_WR;
                    end
                end
            fecs_pkg::FECS_DONE:
                nxt_st = fecs_pkg::FECS_IDLE;
            default:
                nxt_st = fecs_pkg::FECS_IDLE;
        endcase
    end

    // Single writes use index 5 so the table picks the user address
    fecs_cycle #(
        .AW (AW),
        .DW (DW)
    ) u_cycle (
        .clk        (clk),
        .resetn     (resetn),
        .start      (cyc_start),
        .is_read    (is_read),
        .addr       (seq_addr),
        .wdata      (DW'(seq_data)),
        .done       (cyc_done),
        .rdata      (cyc_rdata),
        .f_addr_ff  (f_addr),
        .f_dq_o_ff  (f_dq_o),
        .f_dq_oe_ff (f_dq_oe),
        .f_we_n_ff  (f_we_n),
        .f_oe_n_ff  (f_oe_n),
        .f_ce_n_ff  (f_ce_n),
        .f_dq_i     (f_dq_i)
    );

    ////////////////////////////////////////////////////////////////////////
    // State, order capture, status outputs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_ff      <= fecs_pkg::FECS_IDLE;
            idx_ff     <= 3'h0;
            op_ff      <= fecs_pkg::FECS_OP_READ;
            a_ff       <= '0;
            cmd_ack_ff <= 1'b0;
            rd_data_ff <= '0;
        end else begin
            st_ff      <= nxt_st;
            idx_ff     <= nxt_idx;
            cmd_ack_ff <= (st_ff == fecs_pkg::FECS_DONE);
            if (st_ff == fecs_pkg::FECS_IDLE && cmd_valid) begin
                op_ff <= fecs_pkg::fecs_op_t'(cmd_op);
                a_ff  <= cmd_addr;
            end
            if (cyc_done && is_read)
                rd_data_ff <= cyc_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Window, suspend and busy tracking; abort pulses flash reset
    logic last_wr_done;
    assign last_wr_done = cyc_done && (st_ff == fecs_pkg::FECS_NEXT) &&
                          (idx_ff == 3'h5) && !is_read;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            win_ff           <= 32'h0;
            susp_ff          <= 32'h0;
            window_open_ff   <= 1'b0;
            intr_hold_ff     <= 1'b0;
            suspended_ff     <= 1'b0;
            chip_busy_ff     <= 1'b0;
            flash_reset_n_ff <= 1'b0;
        end else begin
            flash_reset_n_ff <= !abort;
            if (abort) begin
                window_open_ff <= 1'b0;
                intr_hold_ff   <= 1'b0;
                suspended_ff   <= 1'b0;
                chip_busy_ff   <= 1'b0;
                win_ff         <= 32'h0;
                susp_ff        <= 32'h0;
            end else if (last_wr_done) begin
                unique case (op_ff)
                    fecs_pkg::FECS_OP_SECTOR,
                    fecs_pkg::FECS_OP_ADD: begin
                        window_open_ff <= 1'b1;
                        intr_hold_ff   <= 1'b1;
                        win_ff         <= 32'(WINDOW_CYC - 1);
                    end
                    fecs_pkg::FECS_OP_CHIP: chip_busy_ff <= 1'b1;
                    fecs_pkg::FECS_OP_SUSPEND: begin
                        window_open_ff <= 1'b0;
                        intr_hold_ff   <= 1'b0;
                        susp_ff        <= 32'(SUSP_CYC);
                    end
                    fecs_pkg::FECS_OP_RESUME: suspended_ff <= 1'b0;
                    default: ;
                endcase
            end else begin
                if (win_ff != 32'h0)
                    win_ff <= win_ff - 32'h1;
                else begin
                    window_open_ff <= 1'b0;
                    intr_hold_ff   <= 1'b0;
                end
                if (susp_ff == 32'h1)
                    suspended_ff <= 1'b1;
                if (susp_ff != 32'h0)
                    susp_ff <= susp_ff - 32'h1;
                // busy pin release ends chip erase
                if (chip_busy_ff && ready_busy_n_output && win_ff == 32'h0)
                    chip_busy_ff <= 1'b0;
            end
        end
    end
endmodule

//--- test/fecs_flash_model.sv
// Pin-level flash model: erase command decoder, window, suspend, status.
// Assumes the host holds address and data steady up to the strobe rise.
`timescale 1ns/10ps
`include "fecs_regs.svh"
module fecs_flash_model #(
    parameter int WIN_NS   = 200,
    parameter int ERASE_NS = 2000,
    parameter int SUSP_NS  = 40
) (
    input  wire logic [19:0] f_addr,
    input  wire logic [15:0] f_dq_o,
    input  wire logic        f_ce_n,
    input  wire logic        f_we_n,
    input  wire logic        f_oe_n,
    input  wire logic        reset_n,
    output logic [15:0]      f_dq_i,
    output logic             ready_busy_n_output
);
    // Modes: 0 array, 1 chip erase, 2 window, 3 erasing, 4 suspended
    int           mode, step, wr_cnt, rd_cnt, el;
    realtime      win_t;
    logic [255:0] sel = '0;
    logic [7:0]   last_d;
    logic         tgl = 1'b0;
    logic [15:0]  last_q = '0;
    logic [7:0]   d, sa, stat;
    logic [15:0]  rd_val;
    assign d = f_dq_o[7:0];
    assign sa = f_addr[`FECS_SECT_MSB:`FECS_SECT_LSB];

    function automatic logic ok(int s, logic [19:0] a, logic [7:0] v);
        case (s % 3)
            0: ok = a == `FECS_ADDR_UNLOCK1 && v == `FECS_DATA_UNLOCK1;
            1: ok = a == `FECS_ADDR_UNLOCK2 && v == `FECS_DATA_UNLOCK2;
            default: ok = a == `FECS_ADDR_UNLOCK1 && v == `FECS_DATA_SETUP;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Decode each write at the strobe rise
    always @(posedge f_we_n) begin
        if (!f_ce_n && reset_n) begin
            wr_cnt++;
            last_d = d;
            case (mode)
                1: ;
                3: if (d == `FECS_DATA_SUSPEND) fork
                    #(SUSP_NS) if (mode == 3) mode = 4;
                join_none
                2: begin
                    if (d == `FECS_DATA_SECTOR) begin
                        sel[sa] = 1'b1;
                        win_t = $realtime;
                    end else if (d == `FECS_DATA_SUSPEND) begin
                        mode = 4;
                    end else begin
                        mode = 0;
                        sel = '0;
                    end
                end
                // only resume acts; no program modelled
                4: if (d == `FECS_DATA_RESUME) mode = 3;
                default: begin
                    if (step == 5 && d == `FECS_DATA_CHIP) mode = 1;
                    if (step == 5 && d == `FECS_DATA_SECTOR) begin
                        sel[sa] = 1'b1;
                        win_t = $realtime;
                        mode = 2;
                    end
                    step = (step < 5 && ok(step, f_addr, d)) ? step + 1 : 0;
                end
            endcase
        end
    end

    always begin
        #8;
        if (mode == 2 && $realtime - win_t >= WIN_NS) mode = 3;
        if (mode == 1 || mode == 3) el += 8;
        if (el >= ERASE_NS) begin
            mode = 0;
            sel = '0;
            el = 0;
        end
    end

    always @(negedge reset_n) begin
        mode = 0;
        step = 0;
        el = 0;
        sel = '0;
    end

    assign stat = {mode == 4, tgl && mode != 4, 2'h0,
                   mode == 1 || mode == 3, tgl, 2'h0};
    assign rd_val = (mode == 1 || (mode > 1 && sel[sa])) ? {8'h00, stat}
                                                         : f_addr[15:0] ^ 16'h5A5A;
    // Released bus shows the inverse so stale data never passes
    assign f_dq_i = (!f_ce_n && !f_oe_n) ? rd_val : ~last_q;
    assign ready_busy_n_output = !(mode inside {1, 2, 3});
    always @(posedge f_oe_n) begin
        last_q = rd_val;
        tgl = ~tgl;
        rd_cnt++;
    end
endmodule

//--- test/fecs_host_props.sv
// Concurrent checks on the erase sequencer's top-level ports.
// Assumes it is bound into fecs_host with the same window length.
`timescale 1ns/10ps
`include "fecs_regs.svh"
module fecs_host_props #(
    parameter int WINDOW_CYC = `FECS_WINDOW_CYC
) (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        abort,
    input wire logic        window_open_ff,
    input wire logic        intr_hold_ff,
    input wire logic        suspended_ff,
    input wire logic        chip_busy_ff,
    input wire logic        flash_reset_n_ff,
    input wire logic [19:0] f_addr,
    input wire logic [15:0] f_dq_o,
    input wire logic        f_dq_oe,
    input wire logic        f_we_n,
    input wire logic        f_ce_n,
    input wire logic        ready_busy_n_output
);
    int unsigned win_cnt_ff;
    int unsigned nxt_win_cnt;
    logic [7:0]  d_lo;
    assign d_lo = f_dq_o[7:0];
    // Window age, restarted by each strobe
    assign nxt_win_cnt = (window_open_ff && f_we_n) ? win_cnt_ff + 1 : 0;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) win_cnt_ff <= 0;
        else win_cnt_ff <= nxt_win_cnt;
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_intr_hold; intr_hold_ff == window_open_ff; endproperty
    a_intr_hold: assert property (p_intr_hold)
        else $error("interrupt hold differs from window");
    property p_win_len; win_cnt_ff <= WINDOW_CYC + 6; endproperty
    a_win_len: assert property (p_win_len)
        else $error("window held too long");
    property p_chip_quiet; chip_busy_ff && !ready_busy_n_output |-> f_we_n;
    endproperty
    a_chip_quiet: assert property (p_chip_quiet)
        else $error("write issued during chip erase");
    property p_chip_done;
        chip_busy_ff && $rose(ready_busy_n_output) |-> ##[1:3] !chip_busy_ff;
    endproperty
    a_chip_done: assert property (p_chip_done)
        else $error("chip busy kept after ready");
    property p_abort; $rose(abort) |-> ##[1:2] !flash_reset_n_ff; endproperty
    a_abort: assert property (p_abort)
        else $error("abort did not pulse flash reset");
    property p_abort_clear;
        abort |-> ##[1:2] !(window_open_ff || suspended_ff || chip_busy_ff);
    endproperty
    a_abort_clear: assert property (p_abort_clear)
        else $error("abort left tracking set");
    property p_win_cmd;
        window_open_ff && $rose(f_we_n) |-> d_lo inside {8'h30, 8'hB0};
    endproperty
    a_win_cmd: assert property (p_win_cmd)
        else $error("foreign command in window");
    property p_unlock;
        $rose(f_we_n) |-> (d_lo != 8'hAA || f_addr == 20'h00555)
                          && (d_lo != 8'h55 || f_addr == 20'h002AA);
    endproperty
    a_unlock: assert property (p_unlock)
        else $error("unlock code at wrong address");
    property p_strobe; $fell(f_we_n) |-> (!f_we_n)[*5] ##1 f_we_n; endproperty
    a_strobe: assert property (p_strobe)
        else $error("write strobe width wrong");
    property p_hold;
        !f_we_n && $past(!f_we_n) |-> $stable(f_addr) && $stable(f_dq_o)
                                       && f_dq_oe && !f_ce_n;
    endproperty
    a_hold: assert property (p_hold)
        else $error("address or data moved under strobe");
    property p_susp_cut; $rose(suspended_ff) |-> !window_open_ff; endproperty
    a_susp_cut: assert property (p_susp_cut)
        else $error("window open while suspended");
    property p_chip_susp; chip_busy_ff |-> !suspended_ff; endproperty
    a_chip_susp: assert property (p_chip_susp)
        else $error("suspend during chip erase");
endmodule

//--- test/fecs_host_test.sv
// Self-checking bench: sequencer orders against the flash model.
// Assumes the model and checker files are compiled before this one.
`timescale 1ns/10ps
module fecs_host_test;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        cmd_valid = 1'b0;
    logic [2:0]  cmd_op = 3'h0;
    logic [19:0] cmd_addr = 20'h00000;
    logic        abort = 1'b0;
    logic        cmd_ack_ff, window_open_ff, intr_hold_ff, suspended_ff;
    logic        chip_busy_ff, flash_reset_n_ff, f_dq_oe, f_we_n, f_oe_n;
    logic        f_ce_n, ready_busy_n_output;
    logic [19:0] f_addr;
    logic [15:0] f_dq_o, f_dq_i, rd_data_ff;
    int          err_count = 0;
    int          comparisons = 0;
    int          w0;

    always #4 clk = ~clk;

    fecs_host #(.WINDOW_CYC(20), .SUSP_CYC(10)) DUT (
        .clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_ack_ff(cmd_ack_ff), .rd_data_ff(rd_data_ff),
        .window_open_ff(window_open_ff), .intr_hold_ff(intr_hold_ff),
        .suspended_ff(suspended_ff), .chip_busy_ff(chip_busy_ff),
        .flash_reset_n_ff(flash_reset_n_ff), .abort(abort), .f_addr(f_addr),
        .f_dq_o(f_dq_o), .f_dq_oe(f_dq_oe), .f_dq_i(f_dq_i), .f_we_n(f_we_n),
        .f_oe_n(f_oe_n), .f_ce_n(f_ce_n),
        .ready_busy_n_output(ready_busy_n_output));
    fecs_flash_model u_flash (
        .f_addr(f_addr), .f_dq_o(f_dq_o), .f_ce_n(f_ce_n), .f_we_n(f_we_n),
        .f_oe_n(f_oe_n), .reset_n(flash_reset_n_ff), .f_dq_i(f_dq_i),
        .ready_busy_n_output(ready_busy_n_output));

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (err_count == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One order, held until acknowledged
    task automatic order(input logic [2:0] op, input logic [19:0] a);
        @(posedge clk);
        #1;
        cmd_op = op;
        cmd_addr = a;
        cmd_valid = 1'b1;
        for (int i = 0; i < 400; i++) begin
            @(posedge clk);
            #1;
            if (cmd_ack_ff === 1'b1) begin
                cmd_valid = 1'b0;
                return;
            end
        end
        err_count++;
        stop_test();
    endtask
    // Flags: 0 ready, 1 chip busy, 2 suspended, 3 window, 4 flash reset
    task automatic wait_for(input int which, input logic val);
        logic [4:0] f;
        for (int i = 0; i < 2000; i++) begin
            @(posedge clk);
            #1;
            f = {flash_reset_n_ff, window_open_ff, suspended_ff,
                 chip_busy_ff, ready_busy_n_output};
            if (f[which] === val) return;
        end
        err_count++;
        stop_test();
    endtask

    initial begin
        repeat (10) @(posedge clk);
        check("flash_rst", flash_reset_n_ff, 0);
        #1 resetn = 1'b1;
        w0 = u_flash.wr_cnt;
        order(0, 20'h00000);
        check("chip_writes", u_flash.wr_cnt - w0, 6);
        check("chip_code", u_flash.last_d, 8'h10);
        check("chip_busy", chip_busy_ff, 1);
        order(3, 20'h80000);
        order(1, 20'h02000);
        check("busy_refused", u_flash.wr_cnt - w0, 6);
        order(5, 20'h01000);
        check("chip_poll", rd_data_ff[7], 0);
        wait_for(0, 1'b1);
        wait_for(1, 1'b0);
        order(5, 20'h01234);
        check("array_read", rd_data_ff, 16'h486E);
        order(1, 20'h03000);
        check("sel_first", u_flash.sel[3], 1);
        check("win_hold", {window_open_ff, intr_hold_ff}, 2'h3);
        order(2, 20'h0A000);
        check("sel_added", u_flash.sel[10], 1);
        w0 = u_flash.rd_cnt;
        order(5, 20'h03000);
        check("win_no_read", u_flash.rd_cnt - w0, 0);
        wait_for(3, 1'b0);
        order(5, 20'h03000);
        check("timer_out", u_flash.mode, 3);
        check("erase_stat", rd_data_ff[7:0] & 8'h88, 8'h08);
        order(5, 20'h05010);
        check("other_sect", rd_data_ff, 16'h0A4A);
        w0 = u_flash.wr_cnt;
        order(2, 20'h0B000);
        order(4, 20'h03000);
        check("late_refused", u_flash.wr_cnt - w0, 0);
        order(3, 20'h03000);
        wait_for(2, 1'b1);
        check("suspended", u_flash.mode, 4);
        order(5, 20'h03000);
        check("susp_poll", rd_data_ff[7], 1);
        order(5, 20'h06000);
        check("susp_array", rd_data_ff, 16'h3A5A);
        repeat (2) begin
            w0 = u_flash.wr_cnt;
            order(4, 20'h03000);
            order(4, 20'h03000);
            check("one_resume", u_flash.wr_cnt - w0, 1);
            check("resumed", u_flash.mode, 3);
            order(3, 20'h03000);
            wait_for(2, 1'b1);
        end
        order(4, 20'h03000);
        wait_for(0, 1'b1);
        check("sel_clear", u_flash.sel == '0, 1);
        order(1, 20'h07000);
        order(3, 20'h07000);
        check("win_cut", {window_open_ff, u_flash.mode == 4}, 2'h1);
        wait_for(2, 1'b1);
        abort = 1'b1;
        wait_for(4, 1'b0);
        abort = 1'b0;
        wait_for(4, 1'b1);
        check("abort_clear", {suspended_ff, u_flash.mode == 0}, 2'h1);
        order(5, 20'h07000);
        check("after_abort", rd_data_ff, 16'h2A5A);
        stop_test();
    end
endmodule

bind fecs_host fecs_host_props #(.WINDOW_CYC(WINDOW_CYC)) u_props (
    .clk(clk), .resetn(resetn), .abort(abort),
    .window_open_ff(window_open_ff), .intr_hold_ff(intr_hold_ff),
    .suspended_ff(suspended_ff), .chip_busy_ff(chip_busy_ff),
    .flash_reset_n_ff(flash_reset_n_ff), .f_addr(f_addr), .f_dq_o(f_dq_o),
    .f_dq_oe(f_dq_oe), .f_we_n(f_we_n), .f_ce_n(f_ce_n),
    .ready_busy_n_output(ready_busy_n_output));
